// >>> logic/motor_pwm_defs.vh
`ifndef MOTOR_PWM_DEFS_VH
`define MOTOR_PWM_DEFS_VH

// register word indexes
`define ADDR_CTRL_A 4'h0
`define ADDR_CTRL_B 4'h1
`define ADDR_PROTECT 4'h2
`define ADDR_SHUTDOWN 4'h3
`define ADDR_CARRIER 4'h4
`define ADDR_WIDTH_U 4'h5
`define ADDR_WIDTH_V 4'h6
`define ADDR_WIDTH_W 4'h7
`define ADDR_ALT_U 4'h8
`define ADDR_ALT_V 4'h9
`define ADDR_ALT_W 4'hA
`define ADDR_DEAD_TIME 4'hB
`define ADDR_IRQ_DIV 4'hC
`define ADDR_LEVEL_BUF0 4'hD
`define ADDR_LEVEL_BUF1 4'hE
`define ADDR_TIMER_START 4'hF

// motor_ctrl_reg_a fields
`define A_IRQ_CFG_A 0
`define A_IRQ_CFG_B 1
`define A_TIMERS_EN 2
`define A_OUTPUT_EN 3
`define A_GUARD_EN 4
`define A_SHOOT_FLAG 5
`define A_SAWTOOTH 6
`define A_SOFT_TRIG 7

// motor_ctrl_reg_b fields
`define B_CWR_TRIG_EN 0
`define B_MODE1 1
`define B_RELOAD_TIMING 2
`define B_SRC_LO 3
`define B_SRC_HI 4
`define B_DT_DISABLE 5
`define B_DT_EDGE 6
`define B_DT_DIV2 7

// shutdown / polarity register fields
`define S_NMI_EN 0
`define S_SHUTDOWN_EN 1
`define S_HIGH_ACT_LOW 2
`define S_LOW_ACT_LOW 3

// count source dividers of clk_sys
`define DIV_F1 6'h01
`define DIV_F8 6'h08
`define DIV_F2N 6'h04
`define DIV_FC32 6'h20

// reset values
`define RST_CTRL_B 8'h20
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_IRQ_DIV 4'h1

`endif

// >>> logic/three_phase_motor_pwm.v
`timescale 1ns/10ps
`include "motor_pwm_defs.vh"

// Notes on behaviour
// RULE1 - whole motor function runs only while the timers enable bit is 1
// RULE2 - carrier period is (m+1) ticks, doubled in triangular modulation
// RULE3 - phase pulse width is n ticks, doubled in triangular modulation
// RULE4 - dead time is p dead-time ticks or none; tick is f1 or f1/2
// RULE5 - three 8-bit dead-time down counters share one reload register
// RULE6 - phase timers are one-shots for U, V, W; carrier runs as free timer
// RULE7 - low nmi_n cuts the pins only with all four enables set
// RULE8 - output enable clears on reset, shoot-through, write 0, or nmi fall
// RULE9 - timers on and output enable off puts all six pins in high impedance
// RULE10 - mode 1 with irq config a: first irq after n-1 underflows, then every n
// RULE11 - carrier irq rate is one per 1 to 15 carrier periods
// RULE12 - software unlocks protection first, changes modes only with timers stopped
// RULE13 - shoot-through flag is set by hardware, cleared only by guard write 0
// RULE14 - sawtooth needs mode 0 and reload timing 0, set by software
// RULE15 - software sets dead-time edge select only for strictly inverse levels
// RULE16 - mode decode: tri mode 0, tri mode 1, or sawtooth
// RULE17 - alternate widths used only in triangular mode 1
// RULE18 - triangular copies level buffers once after a write; sawtooth every trigger
// RULE19 - transfer trigger: underflow, soft trigger write, or carrier write if enabled
// RULE20 - dead time starts on one-shot falling edge; also on trigger in sawtooth
// RULE21 - high-side and low-side active levels are selectable separately
// RULE22 - each carrier underflow triggers the phase one-shots whose start bits are set
// RULE23 - mode 1 loads alternate width first, then primary, alternating
// RULE24 - with dead time on, each turn-on waits for its phase's dead-time counter to stop
// RULE25 - guard on and both sides of a pair active: all pins high impedance
// RULE26 - pin level from shift register, one-shot state and active level
// RULE27 - after reset timers stop, output enable clears, pins released
module three_phase_motor_pwm (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rd_data,
  // forced cutoff input
  input wire nmi_n,
  // phase pins: bit0..2 high side U,V,W; bit3..5 low side U,V,W
  output reg [5:0] phase_out,
  output reg [5:0] phase_oe_n,
  // carrier interrupt request, one cycle
  output reg carrier_irq
);

  // registers
  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_b_q;
  reg unlock_q;
  reg [3:0] shut_q;
  reg [15:0] carrier_q;
  reg [15:0] width_q [0:2];
  reg [15:0] alt_q [0:2];
  reg [7:0] dt_reload_q;
  reg [3:0] irq_div_q;
  reg [5:0] buf0_q;
  reg [5:0] buf1_q;
  reg [3:0] start_q;
  // internal state
  reg [5:0] shift0_q;
  reg [5:0] shift1_q;
  reg pending_q;
  reg [5:0] psc_q;
  reg dt_tick_q;
  reg [17:0] carr_cnt_q;
  reg [16:0] shot_cnt_q [0:2];
  reg [2:0] alt_next_q;
  reg [7:0] dt_cnt_q [0:2];
  reg [2:0] level_prev_q;
  reg [3:0] irq_cnt_q;
  reg nmi_prev_q;

  wire en = ctrl_a_q[`A_TIMERS_EN];
  wire moe = ctrl_a_q[`A_OUTPUT_EN];
  wire guard = ctrl_a_q[`A_GUARD_EN];
  // mode decode
  wire sawtooth = ctrl_a_q[`A_SAWTOOTH]; // RULE16
  wire mode1 = ~sawtooth & ctrl_b_q[`B_MODE1]; // RULE16
  wire dt_on = ~ctrl_b_q[`B_DT_DISABLE];
  wire wr_a = wr_en & (addr == `ADDR_CTRL_A) & unlock_q; // RULE12
  wire wr_b = wr_en & (addr == `ADDR_CTRL_B) & unlock_q; // RULE12
  wire wr_carrier = wr_en & (addr == `ADDR_CARRIER);
  wire wr_buf = wr_en & ((addr == `ADDR_LEVEL_BUF0) | (addr == `ADDR_LEVEL_BUF1));

  // count source divider from the two select bits
  function [5:0] src_div;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: src_div = `DIV_F1;
        2'h1: src_div = `DIV_F8;
        2'h2: src_div = `DIV_F2N;
        default: src_div = `DIV_FC32;
      endcase
    end
  endfunction

  // pulse length in ticks, doubled for triangular waves
  function [16:0] width_ticks;
    input [15:0] n;
    input saw;
    begin
      width_ticks = saw ? {1'b0, n} : {n, 1'b0};
    end
  endfunction

  // carrier length in ticks; 18 bits so that m = FFFF doubled does not wrap
  function [17:0] period_ticks;
    input [15:0] m;
    input saw;
    begin
      period_ticks = saw ? ({2'b00, m} + 18'h00001) : ({1'b0, m, 1'b0} + 18'h00002);
    end
  endfunction

  wire [5:0] div = src_div(ctrl_b_q[`B_SRC_HI:`B_SRC_LO]);
  wire tick = en & (psc_q == div - 6'h01);
  wire carr_run = en & start_q[0];
  wire underflow = carr_run & tick & (carr_cnt_q == 18'h00001);
  wire soft_trig = wr_a & wr_data[`A_SOFT_TRIG];
  // transfer trigger sources
  wire xfer = en & (underflow | soft_trig |
                    (wr_carrier & ctrl_b_q[`B_CWR_TRIG_EN])); // RULE19
  wire dt_tick = ctrl_b_q[`B_DT_DIV2] ? dt_tick_q : 1'b1; // RULE4

  // phase raw levels, dead-time gating and shoot-through detection
  reg [5:0] act;
  reg [2:0] shot;
  reg [2:0] shot_end;
  reg [2:0] lvl;
  reg both;
  integer k;
  always @* begin
    act = 6'h00;
    shot = 3'h0;
    shot_end = 3'h0;
    lvl = 3'h0;
    both = 1'b0;
    for (k = 0; k < 3; k = k + 1) begin
      shot[k] = shot_cnt_q[k] != 17'h00000;
      // pulse ends at this edge unless a new trigger reloads it
      shot_end[k] = tick & (shot_cnt_q[k] == 17'h00001) & ~underflow; // RULE20
      lvl[k] = shot[k] ? shift1_q[k] : shift0_q[k];
      // second buffer level while the one-shot pulse runs
      act[k] = shot[k] ? shift1_q[k] : shift0_q[k]; // RULE26
      act[k+3] = shot[k] ? shift1_q[k+3] : shift0_q[k+3]; // RULE26
      if (dt_on && dt_cnt_q[k] != 8'h00) begin
        act[k] = 1'b0; // RULE24
        act[k+3] = 1'b0; // RULE24
      end
      if (act[k] && act[k+3]) begin
        both = en & moe; // RULE13
      end
    end
  end

  wire shoot = guard & both; // RULE25
  wire nmi_fall = nmi_prev_q & ~nmi_n;
  wire nmi_armed = shut_q[`S_NMI_EN] & shut_q[`S_SHUTDOWN_EN];
  wire cutoff = nmi_armed & en & moe & ~nmi_n; // RULE7

  // register writes, control bits and hardware clears
  always @(posedge clk_sys) begin
    if (reset) begin
      ctrl_a_q <= `RST_BYTE; // RULE27
      ctrl_b_q <= `RST_CTRL_B;
      unlock_q <= 1'b0;
      shut_q <= 4'h0;
      carrier_q <= `RST_WORD;
      dt_reload_q <= `RST_BYTE;
      irq_div_q <= `RST_IRQ_DIV;
      buf0_q <= 6'h00;
      buf1_q <= 6'h00;
      start_q <= 4'h0; // RULE27
      nmi_prev_q <= 1'b1;
    end else begin
      nmi_prev_q <= nmi_n;
      if (wr_a) begin
        ctrl_a_q[4:0] <= wr_data[4:0];
        ctrl_a_q[`A_SAWTOOTH] <= wr_data[`A_SAWTOOTH];
      end
      // output enable clears win over a write of 1 in the same cycle
      if (shoot || (nmi_fall && nmi_armed)) begin
        ctrl_a_q[`A_OUTPUT_EN] <= 1'b0; // RULE8
      end
      // flag: hardware set wins over the guard clear
      if (shoot) begin
        ctrl_a_q[`A_SHOOT_FLAG] <= 1'b1; // RULE13
      end else if (wr_a && !wr_data[`A_GUARD_EN]) begin
        ctrl_a_q[`A_SHOOT_FLAG] <= 1'b0; // RULE13
      end
      if (wr_b) begin
        ctrl_b_q <= wr_data[7:0];
      end
      if (wr_en) begin
        case (addr)
          `ADDR_PROTECT: unlock_q <= wr_data[0];
          `ADDR_SHUTDOWN: shut_q <= wr_data[3:0];
          `ADDR_CARRIER: carrier_q <= wr_data;
          `ADDR_DEAD_TIME: dt_reload_q <= wr_data[7:0];
          `ADDR_IRQ_DIV: irq_div_q <= wr_data[3:0];
          `ADDR_LEVEL_BUF0: buf0_q <= wr_data[5:0];
          `ADDR_LEVEL_BUF1: buf1_q <= wr_data[5:0];
          `ADDR_TIMER_START: start_q <= wr_data[3:0];
          default: ;
        endcase
      end
    end
  end

  // width registers, primary and alternate per phase
  integer w;
  always @(posedge clk_sys) begin
    if (reset) begin
      for (w = 0; w < 3; w = w + 1) begin
        width_q[w] <= `RST_WORD;
        alt_q[w] <= `RST_WORD;
      end
    end else if (wr_en) begin
      for (w = 0; w < 3; w = w + 1) begin
        if (addr == `ADDR_WIDTH_U + w[3:0]) begin
          width_q[w] <= wr_data;
        end
        if (addr == `ADDR_ALT_U + w[3:0]) begin
          alt_q[w] <= wr_data;
        end
      end
    end
  end

  // prescaler and dead-time half-rate toggle
  always @(posedge clk_sys) begin
    if (reset || !en) begin
      psc_q <= 6'h00; // RULE1
      dt_tick_q <= 1'b0;
    end else begin
      psc_q <= tick ? 6'h00 : psc_q + 6'h01;
      dt_tick_q <= ~dt_tick_q;
    end
  end

  // carrier timer: reloads its period on every underflow
  always @(posedge clk_sys) begin
    if (reset || !carr_run) begin
      carr_cnt_q <= period_ticks(carrier_q, sawtooth); // RULE2
    end else if (tick) begin
      if (carr_cnt_q == 18'h00001) begin
        carr_cnt_q <= period_ticks(carrier_q, sawtooth); // RULE2
      end else begin
        carr_cnt_q <= carr_cnt_q - 18'h00001; // RULE6
      end
    end
  end

  // phase one-shots and dead-time counters
  integer p;
  always @(posedge clk_sys) begin
    if (reset || !en) begin
      for (p = 0; p < 3; p = p + 1) begin
        shot_cnt_q[p] <= 17'h00000; // RULE27
        dt_cnt_q[p] <= 8'h00;
      end
      alt_next_q <= 3'h7;
      level_prev_q <= 3'h0;
    end else begin
      level_prev_q <= lvl;
      for (p = 0; p < 3; p = p + 1) begin
        if (underflow && start_q[p+1]) begin
          // alternate width first in mode 1, primary otherwise
          if (mode1 && alt_next_q[p]) begin
            shot_cnt_q[p] <= width_ticks(alt_q[p], sawtooth); // RULE23 RULE17
          end else begin
            shot_cnt_q[p] <= width_ticks(width_q[p], sawtooth); // RULE22 RULE3
          end
          alt_next_q[p] <= mode1 ? ~alt_next_q[p] : 1'b1; // RULE23
        end else if (!start_q[p+1]) begin
          shot_cnt_q[p] <= 17'h00000; // RULE6
          // a stopped phase timer starts again on its alternate width
          alt_next_q[p] <= 1'b1; // RULE23
        end else if (tick && shot_cnt_q[p] != 17'h00000) begin
          shot_cnt_q[p] <= shot_cnt_q[p] - 17'h00001; // RULE6
        end
        // edge select 1 follows any level change, relying on inverse levels
        if (dt_on && ((!ctrl_b_q[`B_DT_EDGE] && shot_end[p]) ||
            (!ctrl_b_q[`B_DT_EDGE] && sawtooth && xfer) ||
            (ctrl_b_q[`B_DT_EDGE] && (level_prev_q[p] != lvl[p])))) begin
          dt_cnt_q[p] <= dt_reload_q; // RULE20 RULE5 RULE15
        end else if (dt_tick && dt_cnt_q[p] != 8'h00) begin
          dt_cnt_q[p] <= dt_cnt_q[p] - 8'h01; // RULE4 RULE5
        end
      end
    end
  end

  // three-phase output shift register load
  always @(posedge clk_sys) begin
    if (reset) begin
      shift0_q <= 6'h00;
      shift1_q <= 6'h00;
      pending_q <= 1'b0;
    end else begin
      if (xfer && (sawtooth || pending_q || wr_buf)) begin
        shift0_q <= (wr_en && addr == `ADDR_LEVEL_BUF0) ? wr_data[5:0] : buf0_q; // RULE18
        shift1_q <= (wr_en && addr == `ADDR_LEVEL_BUF1) ? wr_data[5:0] : buf1_q; // RULE18
      end
      // once per write in triangular modes
      pending_q <= wr_buf | (pending_q & ~xfer); // RULE18
    end
  end

  // carrier interrupt divider
  wire [3:0] irq_n = (irq_div_q == 4'h0) ? 4'h1 : irq_div_q; // RULE11
  wire [3:0] irq_start = (mode1 && ctrl_a_q[`A_IRQ_CFG_A]) ? 4'h1 : 4'h0; // RULE10
  wire irq_hit = underflow & (irq_cnt_q + 4'h1 >= irq_n);
  // counting from one in mode 1 makes the first request come one underflow early
  always @(posedge clk_sys) begin
    if (reset) begin
      irq_cnt_q <= 4'h0;
      carrier_irq <= 1'b0;
    end else if (!carr_run) begin
      irq_cnt_q <= irq_start; // RULE10
      carrier_irq <= 1'b0;
    end else begin
      carrier_irq <= irq_hit; // RULE11
      if (irq_hit) begin
        irq_cnt_q <= 4'h0; // RULE10
      end else if (underflow) begin
        irq_cnt_q <= irq_cnt_q + 4'h1; // RULE10
      end
    end
  end

  // pin drive: polarity, release and cutoff
  always @(posedge clk_sys) begin
    if (reset) begin
      phase_out <= 6'h00;
      phase_oe_n <= 6'h3F; // RULE27
    end else begin
      phase_out[2:0] <= act[2:0] ^ {3{shut_q[`S_HIGH_ACT_LOW]}}; // RULE21 RULE26
      phase_out[5:3] <= act[5:3] ^ {3{shut_q[`S_LOW_ACT_LOW]}}; // RULE21 RULE26
      if (!en) begin
        phase_oe_n <= 6'h3F; // RULE1
      end else if (!moe || cutoff || shoot) begin
        phase_oe_n <= 6'h3F; // RULE9 RULE7 RULE25
      end else begin
        phase_oe_n <= 6'h00;
      end
    end
  end

  // read port: data only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (reset || !rd_en) begin
      rd_data <= 16'h0000;
    end else begin
      case (addr)
        `ADDR_CTRL_A: rd_data <= {8'h00, 1'b0, ctrl_a_q[6:0]};
        `ADDR_CTRL_B: rd_data <= {8'h00, ctrl_b_q};
        `ADDR_PROTECT: rd_data <= {15'h0000, unlock_q};
        `ADDR_SHUTDOWN: rd_data <= {12'h000, shut_q};
        `ADDR_CARRIER: rd_data <= carr_run ? carr_cnt_q[15:0] : carrier_q;
        `ADDR_WIDTH_U: rd_data <= width_q[0];
        `ADDR_WIDTH_V: rd_data <= width_q[1];
        `ADDR_WIDTH_W: rd_data <= width_q[2];
        `ADDR_ALT_U: rd_data <= alt_q[0];
        `ADDR_ALT_V: rd_data <= alt_q[1];
        `ADDR_ALT_W: rd_data <= alt_q[2];
        `ADDR_DEAD_TIME: rd_data <= {8'h00, dt_reload_q};
        `ADDR_IRQ_DIV: rd_data <= {12'h000, irq_div_q};
        `ADDR_LEVEL_BUF0: rd_data <= {10'h000, shift0_q};
        `ADDR_LEVEL_BUF1: rd_data <= {10'h000, shift1_q};
        default: rd_data <= {12'h000, start_q};
      endcase
    end
  end

endmodule // three_phase_motor_pwm

// >>> dv/pwm_properties.sv
`timescale 1ns/10ps
module pwm_properties (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rd_data,
  // pins
  input wire nmi_n,
  input wire [5:0] phase_out,
  input wire [5:0] phase_oe_n,
  input wire carrier_irq
);
  reg unl_q;
  reg run_q;
  reg grd_q;
  reg [3:0] cfg_q;
  wire [2:0] hi_on = phase_out[2:0] ^ {3{cfg_q[2]}};
  wire [2:0] lo_on = phase_out[5:3] ^ {3{cfg_q[3]}};
  wire wa = wr_en && addr == 4'h0 && unl_q;
  // shadow of what software wrote; hardware clears are not tracked on purpose
  always @(posedge clk_sys) begin
    if (reset) begin
      unl_q <= 1'b0;
      run_q <= 1'b0;
      grd_q <= 1'b0;
      cfg_q <= 4'h0;
    end else begin
      if (wr_en && addr == 4'h2) unl_q <= wr_data[0];
      if (wr_en && addr == 4'h3) cfg_q <= wr_data[3:0];
      if (wa) run_q <= wr_data[2];
      if (wa) grd_q <= wr_data[4];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_reset_pins: assert property (disable iff (1'b0)
    reset |=> phase_oe_n == 6'h3F && phase_out == 6'h00 && !carrier_irq) else $error("reset pins");
  chk_read_idle: assert property (!rd_en |=> rd_data == 16'h0000) else $error("read idle");
  chk_timers_off: assert property (
    !run_q [*3] |-> phase_oe_n == 6'h3F && !carrier_irq) else $error("timers off");
  chk_oe_all_none: assert property (
    phase_oe_n == 6'h00 || phase_oe_n == 6'h3F) else $error("split enables");
  chk_drop_output: assert property (
    wa && wr_data[3:2] == 2'b01 |=> ##[0:2] phase_oe_n == 6'h3F) else $error("output drop");
  chk_nmi_fall: assert property (
    $fell(nmi_n) && cfg_q[1:0] == 2'b11 |-> ##[1:3] phase_oe_n == 6'h3F) else $error("nmi fall");
  chk_nmi_level: assert property (
    (!nmi_n && cfg_q[1:0] == 2'b11) [*3] |-> phase_oe_n == 6'h3F) else $error("nmi level");
  chk_shoot_cut: assert property (
    grd_q && phase_oe_n == 6'h00 && (hi_on & lo_on) != 3'b000 |=> phase_oe_n == 6'h3F)
    else $error("shoot cut");
endmodule // pwm_properties

bind three_phase_motor_pwm pwm_properties u_chk (.clk_sys(clk_sys), .reset(reset), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .nmi_n(nmi_n),
  .phase_out(phase_out), .phase_oe_n(phase_oe_n), .carrier_irq(carrier_irq));

// >>> dv/gate_driver_model.sv
`timescale 1ns/10ps
module gate_driver_model (
  // pins from the controller
  input wire clk_sys,
  input wire [5:0] phase_out,
  input wire [5:0] phase_oe_n,
  input wire hi_act_low,
  input wire lo_act_low,
  // fault request and gate states
  input wire trip,
  output reg nmi_n,
  output wire [2:0] hi_on,
  output wire [2:0] lo_on
);
  // released pins fall to the driver pull-downs, never the last value
  wire [5:0] pin = phase_out & ~phase_oe_n;
  assign hi_on = pin[2:0] ^ {3{hi_act_low}};
  assign lo_on = pin[5:3] ^ {3{lo_act_low}};
  // bridge fault comparator pulls the cutoff line, changing just after the edge
  always @(posedge clk_sys) begin
    nmi_n <= ~trip;
  end
endmodule // gate_driver_model

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [15:0] wr_data = 16'h0000;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg trip = 1'b0;
  reg [3:0] pol = 4'h0;
  wire [15:0] rd_data;
  wire nmi_n;
  wire carrier_irq;
  wire [5:0] phase_out;
  wire [5:0] phase_oe_n;
  wire [2:0] hi_on;
  wire [2:0] lo_on;
  integer mismatches = 0;
  integer n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  three_phase_motor_pwm dut (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .nmi_n(nmi_n), .phase_out(phase_out),
    .phase_oe_n(phase_oe_n), .carrier_irq(carrier_irq));
  gate_driver_model u_drv (.clk_sys(clk_sys), .phase_out(phase_out), .phase_oe_n(phase_oe_n),
    .hi_act_low(pol[2]), .lo_act_low(pol[3]), .trip(trip), .nmi_n(nmi_n), .hi_on(hi_on),
    .lo_on(lo_on));
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // one-cycle strobes launched just after an edge, taken at the next
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge clk_sys);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the taking edge
  task rd(input [3:0] a, input [15:0] m, input [15:0] e, input string nm);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(nm, {16'h0000, e}, {16'h0000, rd_data & m});
    end
  endtask
  task wait_irq;
    integer i;
    begin
      i = 0;
      do begin
        @(posedge clk_sys);
        #1;
        i = i + 1;
      end while (carrier_irq !== 1'b1 && i < 2000);
      if (i >= 2000) begin
        mismatches = mismatches + 1;
        print_verdict;
      end
    end
  endtask
  // timers are stopped around every mode change; counts span one irq gap
  task run(input [7:0] ca, input [7:0] cb, input [3:0] dv, input [3:0] p,
           input integer gap, input integer hi, input integer none);
    integer a, g, h, z;
    begin
      wr(4'hF, 16'h0000);
      wr(4'h1, {8'h00, cb});
      wr(4'h3, {12'h000, p});
      pol <= p;
      wr(4'hC, {12'h000, dv});
      wr(4'h4, 16'h0009);
      // alternate widths differ so that using them where they must be ignored shows
      for (a = 5; a <= 10; a = a + 1) wr(a[3:0], (a < 8) ? 16'h0003 : 16'h0001);
      wr(4'hB, 16'h0002);
      wr(4'hD, 16'h0038);
      wr(4'hE, 16'h0007);
      wr(4'h0, {8'h00, ca});
      wr(4'hF, 16'h000F);
      wait_irq;
      wait_irq;
      g = 0;
      h = 0;
      z = 0;
      do begin
        @(posedge clk_sys);
        #1;
        g = g + 1;
        h = h + hi_on[0];
        z = z + (!hi_on[0] && !lo_on[0]);
      end while (carrier_irq !== 1'b1 && g < 2000);
      chk("gap", gap, g);
      chk("high", hi, h);
      chk("dead", none, z);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd(4'h0, 16'hFFFF, 16'h0000, "ctrl_a");
    rd(4'h1, 16'hFFFF, 16'h0020, "ctrl_b");
    rd(4'hC, 16'hFFFF, 16'h0001, "irq_div");
    chk("oe_n", 32'h3F, {26'h0, phase_oe_n});
    wr(4'h0, 16'h0004);
    rd(4'h0, 16'hFFFF, 16'h0000, "locked");
    wr(4'h2, 16'h0001);
    run(8'h4C, 8'h20, 4'h1, 4'h0, 10, 3, 0);
    run(8'h0C, 8'h20, 4'h1, 4'h0, 20, 6, 0);
    run(8'h4C, 8'h28, 4'h1, 4'h0, 80, 24, 0);
    run(8'h4C, 8'h30, 4'h1, 4'h0, 40, 12, 0);
    run(8'h4C, 8'h38, 4'h1, 4'h0, 320, 96, 0);
    run(8'h4C, 8'h20, 4'h3, 4'h0, 30, 9, 0);
    run(8'h4C, 8'h00, 4'h1, 4'h0, 10, 1, 4);
    run(8'h0C, 8'h00, 4'h1, 4'h0, 20, 6, 2);
    run(8'h4C, 8'h20, 4'h1, 4'hC, 10, 3, 0);
    run(8'h0D, 8'h22, 4'h3, 4'h0, 60, 10, 0);
    wr(4'hF, 16'h0000);
    wr(4'h0, 16'h0008);
    repeat (3) @(posedge clk_sys);
    chk("off", 32'h3F, {26'h0, phase_oe_n});
    run(8'h4C, 8'h20, 4'h1, 4'h0, 10, 3, 0);
    @(posedge clk_sys) trip <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("no_cut", 32'h00, {26'h0, phase_oe_n});
    @(posedge clk_sys) trip <= 1'b0;
    wr(4'h3, 16'h0003);
    @(posedge clk_sys) trip <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("cut", 32'h3F, {26'h0, phase_oe_n});
    rd(4'h0, 16'h0008, 16'h0000, "out_en");
    @(posedge clk_sys) trip <= 1'b0;
    run(8'h4C, 8'h20, 4'h1, 4'h0, 10, 3, 0);
    wr(4'hD, 16'h0009);
    wr(4'hE, 16'h0009);
    wr(4'h0, 16'h005C);
    repeat (30) @(posedge clk_sys);
    rd(4'h0, 16'h0038, 16'h0030, "flag");
    chk("shoot", 32'h3F, {26'h0, phase_oe_n});
    wr(4'h0, 16'h006C);
    rd(4'h0, 16'h0030, 16'h0000, "flag_clr");
    // transfer triggers with the timers stopped, triangular mode
    wr(4'hF, 16'h0000);
    wr(4'h0, 16'h000C);
    wr(4'hD, 16'h0038);
    rd(4'hD, 16'h003F, 16'h0009, "no_xfer");
    wr(4'h0, 16'h008C);
    rd(4'hD, 16'h003F, 16'h0038, "soft_xfer");
    wr(4'h1, 16'h0021);
    wr(4'hD, 16'h0007);
    wr(4'h4, 16'h0009);
    rd(4'hD, 16'h003F, 16'h0007, "cwr_xfer");
    print_verdict;
  end
endmodule // testbench
